// file: rtl/prc_power_ctrl.sv
// Host controller that programs the power rail control bank of the device.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "prc_consts.svh"

// Operation
// - The halve bit is always written as zero.
// - Boost and halve are never both one in a write.
// - Boost is written on before the source select is set.
// - At least one millisecond passes between boost on and select on.
// - Boost with boosted source is never set while the supply is high.
// - Display ready is reported only one hundred milliseconds after power on.
// - Heavy-load modes are written only as software requests them.
// - Level-two reference, low supply: boost 1, halve 0, spare 0, select 1.
// - Level-one reference: boost, halve, spare and select all zero.
// - With main supply selected the boost bit is left cleared, except during the boost settle wait.

module prc_power_ctrl
  import prc_pkg::*;
#(
  parameter int BOOST_CYC = `PRC_BOOST_SETTLE_US * `PRC_CLK_MHZ,
  parameter int LCD_CYC   = `PRC_LCD_SETTLE_MS * 1000 * `PRC_CLK_MHZ
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         axi_awvalid_in,
  output logic              axi_awready_out,
  input  wire logic [3:0]   axi_awaddr_in,
  input  wire logic         axi_wvalid_in,
  output logic              axi_wready_out,
  input  wire logic [31:0]  axi_wdata_in,
  input  wire logic [3:0]   axi_wstrb_in,
  output logic              axi_bvalid_out,
  input  wire logic         axi_bready_in,
  output logic [1:0]        axi_bresp_out,
  input  wire logic         axi_arvalid_in,
  output logic              axi_arready_out,
  input  wire logic [3:0]   axi_araddr_in,
  output logic              axi_rvalid_out,
  input  wire logic         axi_rready_in,
  output logic [31:0]       axi_rdata_out,
  output logic [1:0]        axi_rresp_out,
  input  wire logic         supply_high_in,
  output prc_dev_req_t      dev_req_out,
  output logic              display_ready_out
);

  prc_regs_t r;
  prc_regs_t next_r;
  logic      busy;
  logic      boosted;

  function automatic prc_dev_req_t dev_write(input logic [15:0] addr, input logic [3:0] data);
    prc_dev_req_t q;
    q.wr   = 1'b1;
    q.addr = addr;
    q.data = data;
    return q;
  endfunction

  assign busy              = (r.st != PRC_IDLE) || r.pending;
  assign boosted           = (r.sh_supply == `PRC_SUPPLY_BOOSTED);
  assign axi_awready_out   = !r.aw_have && !r.bvalid;
  assign axi_wready_out    = !r.w_have && !r.bvalid;
  assign axi_arready_out   = !r.rvalid;
  assign axi_bvalid_out    = r.bvalid;
  assign axi_bresp_out     = r.bresp;
  assign axi_rvalid_out    = r.rvalid;
  assign axi_rdata_out     = r.rdata;
  assign axi_rresp_out     = r.rresp;
  assign dev_req_out       = r.dev;
  assign display_ready_out = r.lcd_ready;

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  always_comb begin
    logic want_boost;
    want_boost = r.cmd.ref_two && !r.sup_sync;
    next_r = r;
    next_r.dev.wr = 1'b0;
    next_r.sup_meta = supply_high_in;
    next_r.sup_sync = r.sup_meta;

    // Display level settle timer.
    if (!r.sh_mode[`PRC_POWER_BIT]) begin
      next_r.lcd_cnt   = 32'h0;
      next_r.lcd_ready = 1'b0;
    end else if (r.lcd_cnt != 32'h0) begin
      next_r.lcd_cnt = r.lcd_cnt - 32'h1;
    end else begin
      next_r.lcd_ready = 1'b1;
    end

    case (r.st)
      PRC_IDLE: begin
        if (r.pending || (r.sh_supply[`PRC_BOOST_BIT] && r.sup_sync)) begin
          next_r.pending = 1'b0;
          if (want_boost && !boosted) begin
            next_r.dev = dev_write(`PRC_DEV_SUPPLY_ADDR, `PRC_SUPPLY_BOOST);
            next_r.cnt = 32'(BOOST_CYC - 1);
            next_r.st  = PRC_WAIT_BOOST;
          end else if (want_boost) begin
            next_r.st = PRC_WR_MODE;
          end else begin
            next_r.dev = dev_write(`PRC_DEV_SUPPLY_ADDR, `PRC_SUPPLY_OFF);
            next_r.st  = PRC_WR_MODE;
          end
        end
      end
      PRC_WAIT_BOOST: begin
        if (!want_boost) begin
          next_r.dev = dev_write(`PRC_DEV_SUPPLY_ADDR, `PRC_SUPPLY_OFF);
          next_r.st  = PRC_WR_MODE;
        end else if (r.cnt == 32'h0) begin
          next_r.dev = dev_write(`PRC_DEV_SUPPLY_ADDR, `PRC_SUPPLY_BOOSTED);
          next_r.st  = PRC_WR_MODE;
        end else begin
          next_r.cnt = r.cnt - 32'h1;
        end
      end
      PRC_WR_MODE: begin
        next_r.dev = dev_write(`PRC_DEV_MODE_ADDR,
                               {r.cmd.disp_heavy, r.cmd.core_heavy, 1'b0, r.cmd.display_on});
        if (r.cmd.display_on && !r.sh_mode[`PRC_POWER_BIT]) begin
          next_r.lcd_cnt   = 32'(LCD_CYC - 1);
          next_r.lcd_ready = 1'b0;
        end
        next_r.st = PRC_IDLE;
      end
      default: begin
        next_r.st = PRC_IDLE;
      end
    endcase

    if (next_r.dev.wr) begin
      if (next_r.dev.addr == `PRC_DEV_SUPPLY_ADDR) begin
        next_r.sh_supply = next_r.dev.data;
      end else begin
        next_r.sh_mode = next_r.dev.data;
      end
    end

    // AXI4-Lite write channels.
    if (axi_awvalid_in && axi_awready_out) begin
      next_r.aw_have = 1'b1;
      next_r.awaddr  = axi_awaddr_in;
    end
    if (axi_wvalid_in && axi_wready_out) begin
      next_r.w_have = 1'b1;
      next_r.wdata  = axi_wdata_in[3:0];
      next_r.wstrb0 = axi_wstrb_in[0];
    end
    if (r.aw_have && r.w_have) begin
      next_r.aw_have = 1'b0;
      next_r.w_have  = 1'b0;
      next_r.bvalid  = 1'b1;
      next_r.bresp   = `PRC_RESP_OKAY;
      if (r.awaddr == `PRC_CMD_OFS) begin
        if (r.wstrb0) begin
          next_r.cmd     = prc_cmd_t'(r.wdata);
          next_r.pending = 1'b1;
        end
      end else if (r.awaddr != `PRC_STAT_OFS) begin
        next_r.bresp = `PRC_RESP_SLVERR;
      end
    end
    if (r.bvalid && axi_bready_in) begin
      next_r.bvalid = 1'b0;
    end

    // AXI4-Lite read channels.
    if (axi_arvalid_in && axi_arready_out) begin
      next_r.rvalid = 1'b1;
      next_r.rresp  = `PRC_RESP_OKAY;
      if (axi_araddr_in == `PRC_CMD_OFS) begin
        next_r.rdata = {28'h0, r.cmd};
      end else if (axi_araddr_in == `PRC_STAT_OFS) begin
        next_r.rdata = {20'h0, r.sh_mode, r.sh_supply, r.sup_sync, r.lcd_ready, boosted, busy};
      end else begin
        next_r.rdata = 32'h0;
        next_r.rresp = `PRC_RESP_SLVERR;
      end
    end
    if (r.rvalid && axi_rready_in) begin
      next_r.rvalid = 1'b0;
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r           <= '0;
      r.st        <= PRC_IDLE;
      r.sh_supply <= `PRC_CTRL_RESET;
      r.sh_mode   <= `PRC_CTRL_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  logic [31:0] boost_age;
  logic [31:0] lcd_age;
  logic        supply_wr;
  logic        mode_wr;
  logic        supply_sel;

  assign supply_wr  = r.dev.wr && (r.dev.addr == `PRC_DEV_SUPPLY_ADDR);
  assign mode_wr    = r.dev.wr && (r.dev.addr == `PRC_DEV_MODE_ADDR);
  assign supply_sel = supply_wr && r.dev.data[`PRC_SELECT_BIT];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      boost_age <= 32'h0;
      lcd_age   <= 32'h0;
    end else begin
      boost_age <= !r.sh_supply[`PRC_BOOST_BIT] ? 32'h0 :
                   (boost_age == 32'hffffffff) ? boost_age : boost_age + 32'h1;
      lcd_age   <= !r.sh_mode[`PRC_POWER_BIT] ? 32'h0 :
                   (lcd_age == 32'hffffffff) ? lcd_age : lcd_age + 32'h1;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_halve_kept_zero: assert property (supply_wr |-> !r.dev.data[`PRC_HALVE_BIT])
    else $error("Halve bit written as one.");
  a_boost_halve_excl: assert property (supply_wr |->
    !(r.dev.data[`PRC_BOOST_BIT] && r.dev.data[`PRC_HALVE_BIT]))
    else $error("Boost and halve both written as one.");
  a_select_after_boost: assert property (supply_sel |->
    $past(r.sh_supply[`PRC_BOOST_BIT]))
    else $error("Source select set before boost was on.");
  a_boost_settle_time: assert property (
    (supply_sel && !$past(r.sh_supply[`PRC_SELECT_BIT])) |-> (boost_age >= 32'(BOOST_CYC)))
    else $error("Source select set too soon after boost on.");
  a_wait_cnt_bound: assert property (
    (r.st == PRC_WAIT_BOOST) |-> (r.cnt < 32'(BOOST_CYC)))
    else $error("Boost settle counter out of range.");
  a_supply_limit_off: assert property (supply_sel |-> !$past(r.sup_sync))
    else $error("Boosted source selected while supply is high.");
  a_boost_abort_high: assert property (
    (r.st == PRC_WAIT_BOOST && r.sup_sync) |=> (supply_wr && r.dev.data == `PRC_SUPPLY_OFF))
    else $error("Boost not dropped when supply went high.");
  a_power_as_cmd: assert property (
    mode_wr |-> (r.dev.data[`PRC_POWER_BIT] == $past(r.cmd.display_on)))
    else $error("Display power bit differs from the command.");
  a_lcd_settle_time: assert property ($rose(r.lcd_ready) |-> (lcd_age >= 32'(LCD_CYC)))
    else $error("Display ready reported too early.");
  a_lcd_ready_off: assert property (!r.sh_mode[`PRC_POWER_BIT] |=> !r.lcd_ready)
    else $error("Display ready shown with display power off.");
  a_heavy_as_cmd: assert property (mode_wr |->
    (r.dev.data[3:2] == {$past(r.cmd.disp_heavy), $past(r.cmd.core_heavy)}))
    else $error("Heavy-load bits differ from the command.");
  a_boosted_profile: assert property (
    supply_sel |-> (r.dev.data == `PRC_SUPPLY_BOOSTED))
    else $error("Boosted setting is not the documented profile.");
  a_supply_spare_zero: assert property (supply_wr |-> !r.dev.data[3])
    else $error("Spare supply bit written as one.");
  a_level_one_off: assert property ((supply_wr && !$past(r.cmd.ref_two)) |->
    (r.dev.data == `PRC_SUPPLY_OFF))
    else $error("Level-one reference got a non-zero supply setting.");
  a_main_no_boost: assert property (
    (r.st == PRC_IDLE && !r.sh_supply[`PRC_SELECT_BIT]) |-> !r.sh_supply[`PRC_BOOST_BIT])
    else $error("Boost left on with main supply selected.");
  a_mode_spare_zero: assert property (mode_wr |-> !r.dev.data[1])
    else $error("Spare mode bit written as one.");

  // ****************************************************************
  // Bus handshake checks.
  // ****************************************************************
  a_bresp_hold: assert property ((r.bvalid && !axi_bready_in) |=> (r.bvalid && $stable(r.bresp)))
    else $error("Write response dropped before it was taken.");
  a_rdata_hold: assert property ((r.rvalid && !axi_rready_in) |=> (r.rvalid && $stable(r.rdata)))
    else $error("Read data dropped before it was taken.");

  c_boost_done: cover property (supply_wr && r.dev.data == `PRC_SUPPLY_BOOSTED);
  c_supply_drop: cover property (boosted && r.sup_sync ##[1:4] supply_wr);
  c_lcd_ready: cover property ($rose(r.lcd_ready));
  c_bad_addr: cover property (r.bvalid && r.bresp == `PRC_RESP_SLVERR);
  c_boost_abort: cover property (r.st == PRC_WAIT_BOOST && r.sup_sync);

endmodule

// file: rtl/prc_consts.svh
// Constants for the power rail controller: offsets, field positions, settings, timing.
`ifndef PRC_CONSTS_SVH
`define PRC_CONSTS_SVH

// ****************************************************************
// Controller registers on the AXI4-Lite bus (byte offsets) and bus response codes.
// ****************************************************************
`define PRC_CMD_OFS          4'h0
`define PRC_STAT_OFS         4'h4
`define PRC_RESP_OKAY        2'h0
`define PRC_RESP_SLVERR      2'h2

// ****************************************************************
// Device register addresses and fields.
// ****************************************************************
`define PRC_DEV_SUPPLY_ADDR  16'hff02
`define PRC_DEV_MODE_ADDR    16'hff03
`define PRC_BOOST_BIT        0
`define PRC_HALVE_BIT        1
`define PRC_SELECT_BIT       2
`define PRC_POWER_BIT        0
`define PRC_CORE_HEAVY_BIT   2
`define PRC_DISP_HEAVY_BIT   3
`define PRC_CTRL_RESET       4'h0
`define PRC_SUPPLY_OFF       4'h0
`define PRC_SUPPLY_BOOST     4'h1
`define PRC_SUPPLY_BOOSTED   4'h5

// ****************************************************************
// Timing.
// ****************************************************************
`define PRC_CLK_MHZ          50
`define PRC_BOOST_SETTLE_US  1000
`define PRC_LCD_SETTLE_MS    100

`endif

// file: rtl/prc_pkg.sv
// Types of the power rail controller.
package prc_pkg;

  typedef enum logic [1:0] {
    PRC_IDLE,
    PRC_WAIT_BOOST,
    PRC_WR_MODE
  } prc_state_t;

  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [3:0]  data;
  } prc_dev_req_t;

  typedef struct packed {
    logic disp_heavy;
    logic core_heavy;
    logic ref_two;
    logic display_on;
  } prc_cmd_t;

  typedef struct packed {
    prc_state_t   st;
    logic [31:0]  cnt;
    logic [31:0]  lcd_cnt;
    logic         lcd_ready;
    prc_cmd_t     cmd;
    logic         pending;
    logic [3:0]   sh_supply;
    logic [3:0]   sh_mode;
    prc_dev_req_t dev;
    logic         sup_meta;
    logic         sup_sync;
    logic         aw_have;
    logic [3:0]   awaddr;
    logic         w_have;
    logic [3:0]   wdata;
    logic         wstrb0;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
  } prc_regs_t;

endpackage

// file: tb/prc_dev_model.sv
// Behavioural model of the device power control registers.
`timescale 1ns/1ps

module prc_dev_model
  import prc_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire prc_dev_req_t dev_req_in,
  output logic [3:0]        supply_out,
  output logic [3:0]        mode_out
);
  // ****************************************************************
  // Register storage, written by the controller's requests.
  // ****************************************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      supply_out <= 4'h0;
      mode_out   <= 4'h0;
    end else if (dev_req_in.wr && dev_req_in.addr == 16'hff02) begin
      supply_out <= dev_req_in.data;
    end else if (dev_req_in.wr && dev_req_in.addr == 16'hff03) begin
      mode_out <= dev_req_in.data;
    end
  end
endmodule

// file: tb/test_prc_power_ctrl.sv
// Self-checking bench of the power rail controller.
`timescale 1ns/1ps

module test_prc_power_ctrl;
  import prc_pkg::*;
  localparam int BC = 8;
  localparam int LC = 20;
  logic         clk_in, rst_n_in, awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready, hi, dready, h, prev;
  logic [3:0]   awaddr, araddr, wstrb, sup, mode, c;
  logic [31:0]  wdata, rdata, d;
  logic [1:0]   bresp, rresp, r;
  prc_dev_req_t req;
  int           fails, check_count, cyc, age, hi_cnt;

  prc_power_ctrl #(.BOOST_CYC(BC), .LCD_CYC(LC)) DUT (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .axi_awvalid_in(awvalid),
    .axi_awready_out(awready), .axi_awaddr_in(awaddr), .axi_wvalid_in(wvalid),
    .axi_wready_out(wready), .axi_wdata_in(wdata), .axi_wstrb_in(wstrb),
    .axi_bvalid_out(bvalid), .axi_bready_in(bready), .axi_bresp_out(bresp),
    .axi_arvalid_in(arvalid), .axi_arready_out(arready), .axi_araddr_in(araddr),
    .axi_rvalid_out(rvalid), .axi_rready_in(rready), .axi_rdata_out(rdata),
    .axi_rresp_out(rresp), .supply_high_in(hi), .dev_req_out(req),
    .display_ready_out(dready));
  prc_dev_model MODEL (.clk_in(clk_in), .rst_n_in(rst_n_in), .dev_req_in(req),
    .supply_out(sup), .mode_out(mode));

  always #10 clk_in = ~clk_in;

  // ****************************************************************
  // Compare, bus and closing tasks.
  // ****************************************************************
  task chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk_resp(input string n, input logic [1:0] e, input logic [1:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [31:0] exp_supply(input logic [3:0] cmd, input logic high);
    return (cmd[1] && !high) ? 32'h5 : 32'h0;
  endfunction
  task report_and_stop();
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task axi_wr(input logic [3:0] a, input logic [31:0] dt, output logic [1:0] rs);
    bit done;
    done = 0;
    @(posedge clk_in);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= dt; bready <= 1'b1;
    while (!done) begin
      @(posedge clk_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp; bready <= 1'b0; done = 1;
      end
    end
  endtask
  task axi_rd(input logic [3:0] a, output logic [31:0] dt, output logic [1:0] rs);
    bit done;
    done = 0;
    @(posedge clk_in);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    while (!done) begin
      @(posedge clk_in);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        dt = rdata; rs = rresp; rready <= 1'b0; done = 1;
      end
    end
  endtask
  task wait_idle();
    repeat (3) @(posedge clk_in);
    d = 32'h1;
    while (d[0] !== 1'b0) axi_rd(4'h4, d, r);
  endtask

  // ****************************************************************
  // Watch of the device requests.
  // ****************************************************************
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 60000) begin
      fails++;
      report_and_stop();
    end
    if (rst_n_in && req.wr && req.addr == 16'hff02) begin
      chk_val("halve bit", 32'h0, req.data[1]);
      if (req.data[2]) begin
        chk_val("boost before select", 32'h1, sup[0]);
        chk_val("boost settle", 32'h1, age + 2 >= BC);
        chk_val("select at high supply", 32'h1, hi_cnt < 6);
      end
    end
    if (rst_n_in && req.wr && req.addr == 16'hff03)
      chk_val("supply pair", 32'h1, sup == 4'h0 || sup == 4'h5);
    age = sup[0] ? age + 1 : 0;
    hi_cnt = hi ? hi_cnt + 1 : 0;
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    clk_in = 0; rst_n_in = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0;
    rready = 0; hi = 0; awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0; wstrb = 4'hf;
    fails = 0; check_count = 0; cyc = 0; age = 0; hi_cnt = 0;
    void'($urandom(48));
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    chk_val("model reset", 32'h0, {sup, mode});
    axi_rd(4'h4, d, r);
    chk_val("status reset", 32'h0, d);
    axi_rd(4'h8, d, r);
    chk_val("unmapped data", 32'h0, d);
    chk_resp("unmapped read", 2'h2, r);
    axi_wr(4'hc, 32'h1, r);
    chk_resp("unmapped write", 2'h2, r);
    for (int i = 0; i < 40; i++) begin
      c = (i < 16) ? i[3:0] : 4'($urandom);
      h = (i >= 16) && ($urandom % 4 == 0);
      hi <= h;
      prev = mode[0];
      axi_wr(4'h0, {28'h0, c}, r);
      chk_resp("cmd resp", 2'h0, r);
      wait_idle();
      chk_val("supply reg", exp_supply(c, h), sup);
      chk_val("mode reg", {c[3], c[2], 1'b0, c[0]}, mode);
      axi_rd(4'h4, d, r);
      chk_val("shadows", {mode, sup}, d[11:4]);
      if (c[0] && !prev) chk_val("ready early", 32'h0, dready);
      repeat (LC + 4) @(posedge clk_in);
      chk_val("display ready", c[0], dready);
    end
    hi <= 1'b0;
    axi_wr(4'h0, 32'h2, r);
    wait_idle();
    chk_val("boosted", 32'h5, sup);
    hi <= 1'b1;
    repeat (10) @(posedge clk_in);
    chk_val("auto unboost", 32'h0, sup);
    hi <= 1'b0;
    axi_wr(4'h0, 32'h2, r);
    repeat (3) @(posedge clk_in);
    hi <= 1'b1;
    wait_idle();
    chk_val("unboost in settle", 32'h0, sup);
    hi <= 1'b0;
    axi_wr(4'h0, 32'h2, r);
    axi_wr(4'h0, 32'h1, r);
    wait_idle();
    chk_val("latest cmd supply", 32'h0, sup);
    chk_val("latest cmd mode", 32'h1, mode);
    axi_rd(4'h0, d, r);
    chk_val("cmd readback", 32'h1, d);
    wstrb <= 4'h0;
    axi_wr(4'h0, 32'hf, r);
    wstrb <= 4'hf;
    chk_resp("masked write", 2'h0, r);
    axi_wr(4'h4, 32'hf, r);
    chk_resp("status write", 2'h0, r);
    axi_rd(4'h0, d, r);
    chk_val("cmd kept", 32'h1, d);
    report_and_stop();
  end
endmodule
